/* File: mcb_bridge.v */
// maintenance configuration access bridge
//
// Notes on behaviour
// [RULE1] window hit by ordinary access is maintenance
// [RULE2] remote write to fabric, then status response
// [RULE3] remote read gets one response with status and data
// [RULE4] fabric sends each access to exactly one slave
// [RULE5] slave performs access, answers status and data
// [RULE6] fabric returns slave status and data
// [RULE7] response built from request fields; data only on good reads
// [RULE8] window hit by other than nread, nwrite, nwrite_r gets error
// [RULE9] errored write leaves registers unchanged
// [RULE10] size other than one word gets error
// [RULE11] local port: one read, one write outstanding
// [RULE12] user logic puts 24-bit offset on low address bits
// [RULE13] user logic zeroes top address byte for local space
// [RULE14] two low address bits ignored; word addressing only
// [RULE15] user logic gives address with valid, full write word
// [RULE16] accepted local request issued once fabric free
// [RULE17] local outcome on matching response channel
// [RULE18] nonzero top byte sends access remote with hop count byte-1
// [RULE19] reserved or read-only accesses end without error
// [RULE20] okay maps to done status, any other code to error
`include "mcb_consts.vh"

module mcb_bridge (
  input  wire        clk,            // system clock
  input  wire        resetn,         // sync reset, active low
  input  wire [9:0]  local_config_base_window, // xamsbs and top byte
  output reg  [31:0] base_device_identifier,   // snooped register copy
  input  wire        req_valid,      // link request present
  output reg         req_ready,      // link request taken
  input  wire [2:0]  req_kind,       // packet kind
  input  wire [7:0]  req_size,       // bytes minus one
  input  wire [1:0]  req_xamsbs,     // extended address bits
  input  wire [31:0] req_addr,       // address or offset
  input  wire [31:0] req_wdata,      // write data word
  input  wire [7:0]  req_tid,        // transaction id
  input  wire [15:0] req_srcid,      // requester id
  output reg         rsp_valid,      // link response present
  input  wire        rsp_ready,      // link response taken
  output reg         rsp_kind,       // read or write response
  output reg         rsp_error,      // error status
  output reg         rsp_has_data,   // data word attached
  output reg  [31:0] rsp_data,       // read data
  output reg  [7:0]  rsp_tid,        // echoed id
  output reg  [15:0] rsp_dstid,      // requester id
  input  wire        maint_awvalid,  // local write address
  output reg         maint_awready,
  input  wire [31:0] maint_awaddr,
  input  wire        maint_wvalid,   // local write data
  output reg         maint_wready,
  input  wire [31:0] maint_wdata,
  output reg         maint_bvalid,   // local write response
  input  wire        maint_bready,
  output reg  [1:0]  maint_bresp,
  input  wire        maint_arvalid,  // local read address
  output reg         maint_arready,
  input  wire [31:0] maint_araddr,
  output reg         maint_rvalid,   // local read response
  input  wire        maint_rready,
  output reg  [31:0] maint_rdata,
  output reg  [1:0]  maint_rresp,
  output reg         rmt_valid,      // remote request out
  input  wire        rmt_ready,
  output reg         rmt_write,
  output reg  [7:0]  rmt_hop,
  output reg  [23:0] rmt_offset,
  output reg  [31:0] rmt_wdata,
  input  wire        rmt_rsp_valid,  // remote response in
  output reg         rmt_rsp_ready,
  input  wire        rmt_rsp_error,
  input  wire [31:0] rmt_rsp_data,
  output wire [23:0] cfg_addr,       // fabric slave ports
  output wire [31:0] cfg_wdata,
  output wire [2:0]  cfg_awvalid,
  input  wire [2:0]  cfg_awready,
  output wire [2:0]  cfg_wvalid,
  input  wire [2:0]  cfg_wready,
  input  wire [2:0]  cfg_bvalid,
  output wire [2:0]  cfg_bready,
  input  wire [5:0]  cfg_bresp,
  output wire [2:0]  cfg_arvalid,
  input  wire [2:0]  cfg_arready,
  input  wire [2:0]  cfg_rvalid,
  output wire [2:0]  cfg_rready,
  input  wire [95:0] cfg_rdata,
  input  wire [5:0]  cfg_rresp
);

  localparam S_IDLE = 3'h0;
  localparam S_FAB  = 3'h1;
  localparam S_RMT  = 3'h2;
  localparam S_LINK = 3'h3;
  localparam SRC_LINK = 2'h0;
  localparam SRC_LWR  = 2'h1;
  localparam SRC_LRD  = 2'h2;

  reg  [2:0]  st;
  reg  [1:0]  src;
  reg         go;
  reg         go_write;
  reg  [23:0] go_addr;
  reg  [31:0] go_wdata;
  wire        done;
  wire [1:0]  done_resp;
  wire [31:0] done_rdata;

  // ---------------------------------------------------------------
  // captured requests
  // ---------------------------------------------------------------
  reg         link_got;
  reg  [2:0]  l_kind;
  reg  [7:0]  l_size;
  reg  [9:0]  l_top;
  reg  [23:0] l_off;
  reg  [31:0] l_wdata;
  reg         aw_got;
  reg         w_got;
  reg         ar_got;
  reg         wr_taken;
  reg         rd_taken;
  reg  [31:0] aw_addr;
  reg  [31:0] w_data;
  reg  [31:0] ar_addr;

  wire req_acc  = req_valid & req_ready;
  wire aw_acc   = maint_awvalid & maint_awready;
  wire w_acc    = maint_wvalid & maint_wready;
  wire ar_acc   = maint_arvalid & maint_arready;
  wire wr_clear = maint_bvalid & maint_bready;
  wire rd_clear = maint_rvalid & maint_rready;

  // ---------------------------------------------------------------
  // link request classification
  // ---------------------------------------------------------------
  wire l_maint = (l_kind == `MCB_KIND_MRD) || (l_kind == `MCB_KIND_MWR);
  wire l_io    = (l_kind == `MCB_KIND_NREAD) ||
                 (l_kind == `MCB_KIND_NWRITE) ||
                 (l_kind == `MCB_KIND_NWRITE_R);
  wire l_read  = (l_kind == `MCB_KIND_MRD) || (l_kind == `MCB_KIND_NREAD);
  // [RULE1] window compare
  wire l_hit   = !l_maint && (l_top == local_config_base_window);
  // [RULE8] [RULE10] unsupported kind or size
  wire l_bad   = (l_hit && !l_io) || (l_size != `MCB_SIZE_WORD);
  wire l_quiet = (l_kind == `MCB_KIND_NWRITE);
  wire [7:0] aw_hop = aw_addr[`MCB_HOP_MSB:`MCB_HOP_LSB];
  wire [7:0] ar_hop = ar_addr[`MCB_HOP_MSB:`MCB_HOP_LSB];
  wire       fab_ok = (done_resp == `MCB_RESP_OKAY);

  mcb_cfg_fabric u_fabric (
    .clk         (clk),
    .resetn      (resetn),
    .go          (go),
    .go_write    (go_write),
    .go_addr     (go_addr),
    .go_wdata    (go_wdata),
    .done        (done),
    .done_resp   (done_resp),
    .done_rdata  (done_rdata),
    .cfg_addr    (cfg_addr),
    .cfg_wdata   (cfg_wdata),
    .cfg_awvalid (cfg_awvalid),
    .cfg_awready (cfg_awready),
    .cfg_wvalid  (cfg_wvalid),
    .cfg_wready  (cfg_wready),
    .cfg_bvalid  (cfg_bvalid),
    .cfg_bready  (cfg_bready),
    .cfg_bresp   (cfg_bresp),
    .cfg_arvalid (cfg_arvalid),
    .cfg_arready (cfg_arready),
    .cfg_rvalid  (cfg_rvalid),
    .cfg_rready  (cfg_rready),
    .cfg_rdata   (cfg_rdata),
    .cfg_rresp   (cfg_rresp)
  );

  // ---------------------------------------------------------------
  // channel acceptance
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      req_ready     <= 1'b0;
      maint_awready <= 1'b0;
      maint_wready  <= 1'b0;
      maint_arready <= 1'b0;
      l_kind        <= `MCB_KIND_MRD;
      l_size        <= 8'h00;
      l_top         <= 10'h000;
      l_off         <= 24'h000000;
      l_wdata       <= 32'h00000000;
      rsp_tid       <= 8'h00;
      rsp_dstid     <= 16'h0000;
      aw_addr       <= 32'h00000000;
      w_data        <= 32'h00000000;
      ar_addr       <= 32'h00000000;
    end else begin
      req_ready <= !(link_got || req_acc);
      // [RULE11] one write and one read in flight
      maint_awready <= !((aw_got || aw_acc) && !wr_clear);
      maint_wready  <= !((w_got || w_acc) && !wr_clear);
      maint_arready <= !((ar_got || ar_acc) && !rd_clear);
      if (req_acc) begin
        l_kind    <= req_kind;
        l_size    <= req_size;
        l_top     <= {req_xamsbs, req_addr[`MCB_HOP_MSB:`MCB_HOP_LSB]};
        l_off     <= req_addr[`MCB_OFF_MSB:0];
        l_wdata   <= req_wdata;
        rsp_tid   <= req_tid;
        rsp_dstid <= req_srcid;
      end
      if (aw_acc) begin
        aw_addr <= maint_awaddr;
      end
      if (w_acc) begin
        w_data <= maint_wdata;
      end
      if (ar_acc) begin
        ar_addr <= maint_araddr;
      end
    end
  end

  // ---------------------------------------------------------------
  // issue sequencer
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      st            <= S_IDLE;
      src           <= SRC_LINK;
      go            <= 1'b0;
      go_write      <= 1'b0;
      go_addr       <= 24'h000000;
      go_wdata      <= 32'h00000000;
      link_got      <= 1'b0;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      ar_got        <= 1'b0;
      wr_taken      <= 1'b0;
      rd_taken      <= 1'b0;
      rsp_valid     <= 1'b0;
      rsp_kind      <= `MCB_RSP_READ;
      rsp_error     <= 1'b0;
      rsp_has_data  <= 1'b0;
      rsp_data      <= 32'h00000000;
      maint_bvalid  <= 1'b0;
      maint_bresp   <= `MCB_RESP_OKAY;
      maint_rvalid  <= 1'b0;
      maint_rdata   <= 32'h00000000;
      maint_rresp   <= `MCB_RESP_OKAY;
      rmt_valid     <= 1'b0;
      rmt_write     <= 1'b0;
      rmt_hop       <= 8'h00;
      rmt_offset    <= 24'h000000;
      rmt_wdata     <= 32'h00000000;
      rmt_rsp_ready <= 1'b0;
      base_device_identifier <= `MCB_BASE_DEVICE_ID_RST;
    end else begin
      go <= 1'b0;
      if (req_acc) begin
        link_got <= 1'b1;
      end
      if (aw_acc) begin
        aw_got <= 1'b1;
      end
      if (w_acc) begin
        w_got <= 1'b1;
      end
      if (ar_acc) begin
        ar_got <= 1'b1;
      end
      if (wr_clear) begin
        maint_bvalid <= 1'b0;
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        wr_taken     <= 1'b0;
      end
      if (rd_clear) begin
        maint_rvalid <= 1'b0;
        ar_got       <= 1'b0;
        rd_taken     <= 1'b0;
      end
      case (st)
        S_IDLE: begin
          if (link_got) begin
            src          <= SRC_LINK;
            rsp_kind     <= l_read ? `MCB_RSP_READ : `MCB_RSP_WRITE;
            rsp_has_data <= 1'b0;
            rsp_data     <= 32'h00000000;
            if (!l_maint && !l_hit) begin
              link_got <= 1'b0;
            end else if (l_bad) begin
              // [RULE9] errored write dropped, no access
              rsp_error <= 1'b1;
              rsp_valid <= 1'b1;
              st        <= S_LINK;
            end else begin
              // [RULE2] [RULE3] [RULE14] word access issued
              go       <= 1'b1;
              go_write <= !l_read;
              go_addr  <= {l_off[`MCB_OFF_MSB:`MCB_WORD_LSB], 2'b00};
              go_wdata <= l_wdata;
              st       <= S_FAB;
            end
          end else if (aw_got && w_got && !wr_taken) begin
            // [RULE16] held write goes out when fabric free
            wr_taken <= 1'b1;
            src      <= SRC_LWR;
            if (aw_hop == 8'h00) begin
              go       <= 1'b1;
              go_write <= 1'b1;
              go_addr  <= {aw_addr[`MCB_OFF_MSB:`MCB_WORD_LSB], 2'b00};
              go_wdata <= w_data;
              st       <= S_FAB;
            end else begin
              // [RULE18] remote with hop minus one
              rmt_valid  <= 1'b1;
              rmt_write  <= 1'b1;
              rmt_hop    <= aw_hop - 8'h01;
              rmt_offset <= {aw_addr[`MCB_OFF_MSB:`MCB_WORD_LSB], 2'b00};
              rmt_wdata  <= w_data;
              st         <= S_RMT;
            end
          end else if (ar_got && !rd_taken) begin
            rd_taken <= 1'b1;
            src      <= SRC_LRD;
            if (ar_hop == 8'h00) begin
              go       <= 1'b1;
              go_write <= 1'b0;
              go_addr  <= {ar_addr[`MCB_OFF_MSB:`MCB_WORD_LSB], 2'b00};
              st       <= S_FAB;
            end else begin
              rmt_valid  <= 1'b1;
              rmt_write  <= 1'b0;
              rmt_hop    <= ar_hop - 8'h01;
              rmt_offset <= {ar_addr[`MCB_OFF_MSB:`MCB_WORD_LSB], 2'b00};
              rmt_wdata  <= 32'h00000000;
              st         <= S_RMT;
            end
          end
        end
        S_FAB: begin
          if (done) begin
            // [RULE19] slave code passed as is
            if (go_write && fab_ok &&
                go_addr == `MCB_BASE_DEVICE_ID_OFF) begin
              base_device_identifier <= go_wdata;
            end
            if (src == SRC_LINK) begin
              // [RULE7] [RULE20] status and data for good reads
              rsp_error    <= !fab_ok;
              rsp_has_data <= !go_write && fab_ok;
              rsp_data     <= (!go_write && fab_ok) ? done_rdata :
                              32'h00000000;
              if (l_quiet && fab_ok) begin
                link_got <= 1'b0;
                st       <= S_IDLE;
              end else begin
                rsp_valid <= 1'b1;
                st        <= S_LINK;
              end
            end else if (src == SRC_LWR) begin
              // [RULE17] local write answer
              maint_bvalid <= 1'b1;
              maint_bresp  <= done_resp;
              st           <= S_IDLE;
            end else begin
              maint_rvalid <= 1'b1;
              maint_rdata  <= done_rdata;
              maint_rresp  <= done_resp;
              st           <= S_IDLE;
            end
          end
        end
        S_RMT: begin
          if (rmt_valid && rmt_ready) begin
            rmt_valid     <= 1'b0;
            rmt_rsp_ready <= 1'b1;
          end
          if (rmt_rsp_ready && rmt_rsp_valid) begin
            rmt_rsp_ready <= 1'b0;
            if (src == SRC_LWR) begin
              maint_bvalid <= 1'b1;
              maint_bresp  <= rmt_rsp_error ? `MCB_RESP_SLVERR :
                              `MCB_RESP_OKAY;
            end else begin
              maint_rvalid <= 1'b1;
              maint_rdata  <= rmt_rsp_data;
              maint_rresp  <= rmt_rsp_error ? `MCB_RESP_SLVERR :
                              `MCB_RESP_OKAY;
            end
            st <= S_IDLE;
          end
        end
        S_LINK: begin
          if (rsp_ready) begin
            rsp_valid <= 1'b0;
            link_got  <= 1'b0;
            st        <= S_IDLE;
          end
        end
        default: begin
          st <= S_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: mcb_consts.vh */
// constants of the maintenance configuration access bridge
`ifndef MCB_CONSTS_VH
`define MCB_CONSTS_VH

// ---------------------------------------------------------------
// link request kinds
// ---------------------------------------------------------------
`define MCB_KIND_MRD      3'h0
`define MCB_KIND_MWR      3'h1
`define MCB_KIND_NREAD    3'h2
`define MCB_KIND_NWRITE   3'h3
`define MCB_KIND_NWRITE_R 3'h4

// ---------------------------------------------------------------
// link response kinds
// ---------------------------------------------------------------
`define MCB_RSP_READ      1'h0
`define MCB_RSP_WRITE     1'h1

// ---------------------------------------------------------------
// sizes, status, address fields
// ---------------------------------------------------------------
`define MCB_SIZE_WORD     8'h03
`define MCB_RESP_OKAY     2'h0
`define MCB_RESP_SLVERR   2'h2
`define MCB_HOP_MSB       31
`define MCB_HOP_LSB       24
`define MCB_OFF_MSB       23
`define MCB_WORD_LSB      2

// ---------------------------------------------------------------
// fabric decode windows (offset ranges, inclusive)
// ---------------------------------------------------------------
`define MCB_PHY_LO        24'h000100
`define MCB_PHY_HI        24'h0003ff
`define MCB_BUF_LO        24'h000400
`define MCB_BUF_HI        24'h0007ff
`define MCB_SEL_LOG       2'h0
`define MCB_SEL_BUF       2'h1
`define MCB_SEL_PHY       2'h2

// ---------------------------------------------------------------
// base_device_identifier register
// ---------------------------------------------------------------
`define MCB_BASE_DEVICE_ID_OFF 24'h000060
`define MCB_BASE_DEVICE_ID_RST 32'h00000000

`endif

/* File: mcb_cfg_fabric.v */
// configuration fabric: one access to one of three slaves
`include "mcb_consts.vh"

module mcb_cfg_fabric (
  input  wire        clk,          // system clock
  input  wire        resetn,       // sync reset, active low
  input  wire        go,           // start access, one cycle
  input  wire        go_write,     // access is a write
  input  wire [23:0] go_addr,      // word aligned offset
  input  wire [31:0] go_wdata,     // write data
  output reg         done,         // access finished, one cycle
  output reg  [1:0]  done_resp,    // slave response code
  output reg  [31:0] done_rdata,   // slave read data
  output reg  [23:0] cfg_addr,     // shared slave address
  output reg  [31:0] cfg_wdata,    // shared slave write data
  output reg  [2:0]  cfg_awvalid,  // per slave
  input  wire [2:0]  cfg_awready,  // per slave
  output reg  [2:0]  cfg_wvalid,   // per slave
  input  wire [2:0]  cfg_wready,   // per slave
  input  wire [2:0]  cfg_bvalid,   // per slave
  output reg  [2:0]  cfg_bready,   // per slave
  input  wire [5:0]  cfg_bresp,    // 2 bits per slave
  output reg  [2:0]  cfg_arvalid,  // per slave
  input  wire [2:0]  cfg_arready,  // per slave
  input  wire [2:0]  cfg_rvalid,   // per slave
  output reg  [2:0]  cfg_rready,   // per slave
  input  wire [95:0] cfg_rdata,    // 32 bits per slave
  input  wire [5:0]  cfg_rresp     // 2 bits per slave
);

  localparam F_IDLE = 2'h0;
  localparam F_ADDR = 2'h1;
  localparam F_RESP = 2'h2;

  reg [1:0] st;
  reg [1:0] sel;
  reg       wr;

  // ---------------------------------------------------------------
  // offset decode
  // ---------------------------------------------------------------
  // [RULE4] one slave per offset
  wire [1:0] dec = (go_addr >= `MCB_PHY_LO && go_addr <= `MCB_PHY_HI) ?
                   `MCB_SEL_PHY :
                   (go_addr >= `MCB_BUF_LO && go_addr <= `MCB_BUF_HI) ?
                   `MCB_SEL_BUF : `MCB_SEL_LOG;
  wire [2:0] oh      = 3'h1 << dec;
  wire [2:0] sel_oh  = 3'h1 << sel;
  wire [2:0] aw_left = cfg_awvalid & ~cfg_awready;
  wire [2:0] w_left  = cfg_wvalid & ~cfg_wready;
  wire [2:0] ar_left = cfg_arvalid & ~cfg_arready;

  // ---------------------------------------------------------------
  // access sequencing
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    if (!resetn) begin
      st          <= F_IDLE;
      sel         <= `MCB_SEL_LOG;
      wr          <= 1'b0;
      done        <= 1'b0;
      done_resp   <= `MCB_RESP_OKAY;
      done_rdata  <= 32'h00000000;
      cfg_addr    <= 24'h000000;
      cfg_wdata   <= 32'h00000000;
      cfg_awvalid <= 3'h0;
      cfg_wvalid  <= 3'h0;
      cfg_bready  <= 3'h0;
      cfg_arvalid <= 3'h0;
      cfg_rready  <= 3'h0;
    end else begin
      done <= 1'b0;
      case (st)
        F_IDLE: begin
          if (go) begin
            sel       <= dec;
            wr        <= go_write;
            cfg_addr  <= go_addr;
            cfg_wdata <= go_wdata;
            if (go_write) begin
              cfg_awvalid <= oh;
              cfg_wvalid  <= oh;
            end else begin
              cfg_arvalid <= oh;
            end
            st <= F_ADDR;
          end
        end
        F_ADDR: begin
          cfg_awvalid <= aw_left;
          cfg_wvalid  <= w_left;
          cfg_arvalid <= ar_left;
          if (aw_left == 3'h0 && w_left == 3'h0 && ar_left == 3'h0) begin
            if (wr) begin
              cfg_bready <= sel_oh;
            end else begin
              cfg_rready <= sel_oh;
            end
            st <= F_RESP;
          end
        end
        F_RESP: begin
          // [RULE5] [RULE6] slave answer back
          if (wr && (cfg_bvalid & cfg_bready) != 3'h0) begin
            done       <= 1'b1;
            done_resp  <= cfg_bresp[{sel, 1'b0} +: 2];
            done_rdata <= 32'h00000000;
            cfg_bready <= 3'h0;
            st         <= F_IDLE;
          end else if (!wr && (cfg_rvalid & cfg_rready) != 3'h0) begin
            done       <= 1'b1;
            done_resp  <= cfg_rresp[{sel, 1'b0} +: 2];
            done_rdata <= cfg_rdata[{sel, 5'h00} +: 32];
            cfg_rready <= 3'h0;
            st         <= F_IDLE;
          end
        end
        default: begin
          st <= F_IDLE;
        end
      endcase
    end
  end

endmodule

/* File: mcb_bridge_checker.sv */
// assertions on the bridge ports
`include "mcb_consts.vh"
module mcb_bridge_checker (
  input        clk, resetn, req_valid, req_ready, rsp_valid, rsp_ready,
  input        rsp_kind, rsp_error, rsp_has_data, maint_awready,
  input        maint_bvalid, maint_bready,
  input [2:0]  req_kind, cfg_awvalid, cfg_arvalid,
  input [7:0]  req_size,
  input [31:0] rsp_data,
  input [23:0] cfg_addr
);
  timeunit 1ns / 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  a_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("rsp not held");
  a_req_blocked: assert property (
    rsp_valid |-> !req_ready) else $error("req taken early");
  a_good_data: assert property (
    rsp_valid && rsp_has_data |-> !rsp_error && rsp_kind == `MCB_RSP_READ)
    else $error("bad data flag");
  a_no_data: assert property (
    rsp_valid && !rsp_has_data |-> rsp_data == 32'h0)
    else $error("stray data");
  a_size_err: assert property (
    req_valid && req_ready && req_kind < 3'h2 && req_size != `MCB_SIZE_WORD
    |-> ##[1:3] rsp_valid && rsp_error) else $error("size not refused");
  a_one_slave: assert property (
    $onehot0(cfg_awvalid | cfg_arvalid)) else $error("two slaves");
  a_word_addr: assert property (
    |(cfg_awvalid | cfg_arvalid) |-> cfg_addr[1:0] == 2'h0)
    else $error("unaligned offset");
  a_one_write: assert property (
    maint_bvalid |-> !maint_awready) else $error("second write");
  cover property (rsp_valid && rsp_ready && rsp_has_data);
  cover property (rsp_valid && rsp_error);
  cover property (maint_bvalid && maint_bready);
endmodule
bind mcb_bridge mcb_bridge_checker chk_i (.*);

/* File: mcb_cfg_model.sv */
// register slaves behind the fabric
module mcb_cfg_model (
  input               clk, stall,
  input [23:0]        bad_off, cfg_addr,
  input [31:0]        cfg_wdata,
  input [2:0]         cfg_awvalid, cfg_wvalid, cfg_bready, cfg_arvalid,
  input [2:0]         cfg_rready,
  output [2:0]        cfg_awready, cfg_wready, cfg_arready,
  output logic [2:0]  cfg_bvalid, cfg_rvalid,
  output logic [5:0]  cfg_bresp, cfg_rresp,
  output logic [95:0] cfg_rdata
);
  timeunit 1ns / 1ns;
  logic [31:0] mem [0:1023];
  wire         go = !stall && cfg_bvalid == 3'h0 && cfg_rvalid == 3'h0;
  wire [1:0]   code = cfg_addr[23:2] == bad_off[23:2] ? 2'h2 : 2'h0;
  initial begin
    {cfg_bvalid, cfg_rvalid} = 6'h00;
    foreach (mem[i]) mem[i] = 32'h0;
  end
  assign cfg_awready = {3{go}} & cfg_awvalid & cfg_wvalid;
  assign cfg_wready = cfg_awready;
  assign cfg_arready = {3{go}} & cfg_arvalid;
  always @(posedge clk) begin
    cfg_bvalid <= (cfg_bvalid & ~cfg_bready) | cfg_awready;
    cfg_rvalid <= (cfg_rvalid & ~cfg_rready) | cfg_arready;
    if (|cfg_awready) cfg_bresp <= {3{code}};
    if (|cfg_arready) cfg_rresp <= {3{code}};
    if (|cfg_arready) cfg_rdata <= {3{mem[cfg_addr[11:2]]}};
    if (|cfg_awready && code == 2'h0) mem[cfg_addr[11:2]] <= cfg_wdata;
  end
endmodule

/* File: tb.sv */
// random and corner bench of the bridge
`include "mcb_consts.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam [23:0] BAD = 24'h000104;
  localparam [9:0] WIN = 10'h2a5;
  logic clk = 0, resetn = 0, stall = 0, rsp_ready = 0, maint_bready = 0;
  logic maint_rready = 0, req_valid = 0, maint_awvalid = 0, maint_wvalid = 0;
  logic maint_arvalid = 0, rmt_ready = 1, rmt_rsp_valid = 0, rmt_rsp_error = 0;
  logic [2:0] req_kind = 0;
  logic [7:0] req_size = 0, req_tid = 0;
  logic [1:0] req_xamsbs = 0;
  logic [15:0] req_srcid = 0;
  logic [31:0] req_addr = 0, req_wdata = 0, maint_awaddr = 0, maint_wdata = 0;
  logic [31:0] maint_araddr = 0, rmt_rsp_data = 32'hc0de0000, rr, d, rq;
  logic [31:0] sh [0:1023];
  logic [23:0] bad_off = BAD, o;
  logic [9:0] local_config_base_window = WIN;
  wire [31:0] base_device_identifier, rsp_data, maint_rdata, rmt_wdata, cfg_wdata;
  wire [23:0] rmt_offset, cfg_addr;
  wire [7:0] rsp_tid, rmt_hop;
  wire [15:0] rsp_dstid;
  wire [1:0] maint_bresp, maint_rresp;
  wire [2:0] cfg_awvalid, cfg_awready, cfg_wvalid, cfg_wready, cfg_bvalid;
  wire [2:0] cfg_bready, cfg_arvalid, cfg_arready, cfg_rvalid, cfg_rready;
  wire [5:0] cfg_bresp, cfg_rresp;
  wire [95:0] cfg_rdata;
  wire req_ready, rsp_valid, rsp_kind, rsp_error, rsp_has_data, rmt_valid;
  wire maint_awready, maint_wready, maint_bvalid, maint_arready, maint_rvalid;
  wire rmt_write, rmt_rsp_ready;
  integer seed = 32'h1750, bad_count = 0, total_checks = 0;
  mcb_bridge uut (.*);
  mcb_cfg_model model (.*);
  initial forever #50 clk = ~clk;
  always @(posedge clk) begin
    rr = $random(seed);
    {rsp_ready, maint_bready} <= {rr[0] | rr[1], rr[2] | rr[3]};
    {maint_rready, stall} <= {rr[4] | rr[5], rr[6] & rr[7]};
    rmt_rsp_valid <= rmt_rsp_ready & ~rmt_rsp_valid;
    if (rmt_valid) rq <= {rmt_hop[6:0], rmt_write, rmt_offset};
  end
  task automatic chk(input [31:0] g, input [31:0] x);
    total_checks++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  function automatic logic ferr(input [2:0] k, input [7:0] s, input [23:0] a);
    return s != `MCB_SIZE_WORD || k > `MCB_KIND_NWRITE_R || a[23:2] == BAD[23:2];
  endfunction
  task automatic link(input [2:0] k, input [7:0] s, input [23:0] a,
    input [31:0] v);
    logic e, rd;
    @(posedge clk);
    e = ferr(k, s, a);
    rd = k == `MCB_KIND_MRD || k == `MCB_KIND_NREAD;
    {req_valid, req_kind, req_size, req_xamsbs} <= {1'b1, k, s, WIN[9:8]};
    req_addr <= {(k < 3'h2 ? 8'h0 : WIN[7:0]), a};
    {req_wdata, req_tid, req_srcid} <= {v, v[7:0], v[31:16]};
    do @(posedge clk); while (!req_ready);
    req_valid <= 0;
    if (!rd && !e) sh[a[11:2]] = v;
    if (k == `MCB_KIND_NWRITE && !e) return;
    do @(posedge clk); while (!(rsp_valid && rsp_ready));
    chk(rsp_data, rd && !e ? sh[a[11:2]] : 32'h0);
    chk({rsp_tid, rsp_dstid, 5'h0, rsp_kind && k < 5, rsp_error, rsp_has_data},
      {v[7:0], v[31:16], 5'h0, !rd && k < 5, e, rd && !e});
  endtask
  task automatic loc(input w, input [31:0] a, input [31:0] v);
    logic e, ga, gw;
    @(posedge clk);
    e = a[31:24] == 8'h0 && a[23:2] == BAD[23:2];
    {ga, gw} = {1'b0, !w};
    {maint_awaddr, maint_araddr, maint_wdata} <= {a, a, v};
    {maint_awvalid, maint_wvalid, maint_arvalid} <= {w, w, !w};
    while (!(ga && gw)) begin
      @(posedge clk);
      ga = ga | (w ? maint_awready : maint_arready);
      gw = gw | maint_wready;
      {maint_awvalid, maint_wvalid, maint_arvalid} <= {w & !ga, w & !gw, !w & !ga};
    end
    if (w && !e) sh[a[11:2]] = v;
    do @(posedge clk);
    while (!(w ? maint_bvalid && maint_bready : maint_rvalid && maint_rready));
    chk(w ? maint_bresp : maint_rresp, e ? `MCB_RESP_SLVERR : `MCB_RESP_OKAY);
    if (!w && !e) chk(maint_rdata, a[31:24] ? rmt_rsp_data : sh[a[11:2]]);
  endtask
  task print_verdict;
    if (bad_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    foreach (sh[i]) sh[i] = 32'h0;
    repeat (12) @(posedge clk);
    resetn <= 1;
    chk(base_device_identifier, `MCB_BASE_DEVICE_ID_RST);
    link(`MCB_KIND_MWR, 8'h07, 24'h60, 32'h1234abcd);
    link(`MCB_KIND_MWR, 8'h03, 24'h61, 32'h5a5a0001);
    chk(base_device_identifier, 32'h5a5a0001);
    loc(0, 32'h00000060, 0);
    for (int k = 5; k < 8; k++) link(k[2:0], 8'h03, 24'h70, 32'h77);
    loc(0, 32'h03000040, 0);
    chk(rq, 32'h04000040);
    repeat (60) begin
      rr = $random(seed);
      d = $random(seed);
      o = rr[7] ? BAD : {13'h0, rr[18:8]};
      if (rr[2:0] < 3'h2) loc(!rr[0], {8'h0, o}, d);
      else link(rr[2:0] - 3'h2, rr[11:9] ? 8'h03 : 8'h07, o, d);
    end
    print_verdict;
  end
  initial begin
    #2000000;
    bad_count++;
    print_verdict;
  end
endmodule
